// [rtl/fault_blank_pkg.sv]
// Purpose: shared constants for the fault and blanking supervisor
// Assumes: REF_CLK at 100 MHz
// Notes: blanking counts are in motor-oscillator ticks
package fault_blank_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RESET_PHASE_MS = 40;
  localparam int unsigned RESET_PHASE_CYC = CLK_HZ / 1000 * RESET_PHASE_MS;
  localparam int unsigned CHOP_PERIOD_TICKS = 8;
  localparam logic [2:0] BLANK_SHORT_TICKS = 3'h3;
  localparam logic [2:0] BLANK_LONG_TICKS = 3'h6;
  localparam logic [1:0] BLANK_SEL_SHORT = 2'h2;
  localparam logic [1:0] BLANK_SEL_LONG = 2'h1;
  localparam int unsigned SETUP_AB_HI_BIT = 4;
  localparam int unsigned SETUP_AB_LO_BIT = 3;
  localparam int unsigned SETUP_CD_HI_BIT = 5;
  localparam int unsigned SETUP_CD_LO_BIT = 6;
  localparam int unsigned BRIDGE_COUNT = 4;
endpackage

// [rtl/blank_if.sv]
// Purpose: per-bridge blanking control bundle
// Assumes: one clock shared by both ends
// Notes: tick is a one-cycle motor-oscillator enable
interface blank_if;
  logic tick;
  logic phase;
  logic [1:0] sel;
  logic blank;
  modport ctrl (output tick, output phase, output sel, input blank);
  modport unit (input tick, input phase, input sel, output blank);
endinterface

// [rtl/bridge_blanker.sv]
// Purpose: blanking window generator for one dc-motor bridge
// Assumes: tick is a single-cycle enable
// Notes: unknown select pattern gives no blanking
module bridge_blanker
  import fault_blank_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chop_start,
  blank_if.unit bi
);
  logic phase_q, phase_d;
  logic [2:0] cnt_q, cnt_d;
  logic [2:0] len;

  always_comb begin
    unique case (bi.sel)
      BLANK_SEL_SHORT: len = BLANK_SHORT_TICKS;
      BLANK_SEL_LONG: len = BLANK_LONG_TICKS;
      default: len = 3'h0;
    endcase
    phase_d = bi.phase;
    cnt_d = cnt_q;
    if (bi.phase != phase_q || chop_start) begin
      cnt_d = len;
    end else if (bi.tick && cnt_q != 3'h0) begin
      cnt_d = cnt_q - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 1'b0;
      cnt_q <= 3'h0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
    end
  end

  assign bi.blank = (cnt_q != 3'h0);
endmodule

// [rtl/motor_fault_blanking_supervisor.sv]
// Purpose: blanking insertion, fault shutdown and system reset output
// Assumes: supply comparators and fault flags arrive as async levels
// Notes: protection control bits steer the fault responses when nonzero

// Operation
// - blank each bridge on phase reversal and each eight-tick chopping cycle
// - setup bit pairs pick blanking length: (1,0) three ticks, (0,1) six ticks
// - every low or high phase of the reset output lasts at least 40 ms unless external reset cuts it
// - motor shutdown clears only on supply below 4.5 V, sleep rising edge or reset
// - converters released on rising threshold, stopped below falling threshold
// - with protection control bits nonzero, faults latch only while converters run and motor overcurrent gives no reset pulse
// - shutdown faults latch until power-on reset or external reset
// - external reset stops converters and motor, clears state, reruns start-up
module motor_fault_blanking_supervisor
  import fault_blank_pkg::*;
#(
  parameter int unsigned RESET_PHASE_CYCLES = RESET_PHASE_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic MOTOR_OSC_CLOCK,
  input wire logic [7:0] SETUP_BITS,
  input wire logic [7:0] EXTENDED_PROTECTION_CONFIG,
  input wire logic [3:0] BRIDGE_PHASE,
  input wire logic LOW_POWER_REQUEST_IN,
  input wire logic EXT_RESET_IN,
  input wire logic SUPPLY_RISE_THRESHOLD,
  input wire logic SUPPLY_FALL_THRESHOLD,
  input wire logic SUPPLY_BELOW_4V5,
  input wire logic [2:0] CONV_OVERCURRENT,
  input wire logic [2:0] CONV_OVERVOLTAGE,
  input wire logic MOTOR_OVERCURRENT,
  input wire logic THERMAL_SHUTDOWN,
  output logic [3:0] BLANK_INTERVAL,
  output logic CONVERTER_ENABLE,
  output logic MOTOR_ENABLE,
  output logic SYSTEM_RESET_OUT_LOW
);
  localparam int unsigned NSYNC = 17;
  logic [NSYNC-1:0] s1_q, s2_q, s3_q, st_q;
  logic [NSYNC-1:0] async_in;
  logic osc, sleep_n, ext_rst, vrise, vfall, vlow, mocp, tsd;
  logic [2:0] cocp, covp;
  logic osc_prev_q, sleep_prev_q;
  logic tick, sleep_rise;

  assign async_in = {MOTOR_OSC_CLOCK, LOW_POWER_REQUEST_IN, EXT_RESET_IN, SUPPLY_RISE_THRESHOLD,
                     SUPPLY_FALL_THRESHOLD, SUPPLY_BELOW_4V5, CONV_OVERCURRENT, CONV_OVERVOLTAGE,
                     MOTOR_OVERCURRENT, THERMAL_SHUTDOWN, 3'h0};

  // a level only moves once the last two stages agree, filtering single-cycle noise
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      st_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= (s2_q & s3_q) | (st_q & (s2_q | s3_q));
    end
  end

  assign {osc, sleep_n, ext_rst, vrise, vfall, vlow, cocp, covp, mocp, tsd} = st_q[NSYNC-1:3];

  logic hold_rst;
  assign hold_rst = ext_rst;
  assign tick = osc && !osc_prev_q;
  assign sleep_rise = sleep_n && !sleep_prev_q;

  // chopping period counter in motor-oscillator ticks
  logic [2:0] chop_q, chop_d;
  logic chop_start;
  always_comb begin
    chop_d = chop_q;
    if (tick) begin
      chop_d = chop_q + 3'h1;
    end
  end
  assign chop_start = tick && (chop_q == 3'(CHOP_PERIOD_TICKS - 1));

  blank_if bif [BRIDGE_COUNT] ();
  genvar g;
  generate
    for (g = 0; g < BRIDGE_COUNT; g++) begin : gen_br
      assign bif[g].tick = tick;
      assign bif[g].phase = BRIDGE_PHASE[g];
      if (g < 2) begin : gen_ab
        assign bif[g].sel = {SETUP_BITS[SETUP_AB_HI_BIT], SETUP_BITS[SETUP_AB_LO_BIT]};
      end else begin : gen_cd
        assign bif[g].sel = {SETUP_BITS[SETUP_CD_HI_BIT], SETUP_BITS[SETUP_CD_LO_BIT]};
      end
      bridge_blanker u_blank (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .chop_start(chop_start),
        .bi(bif[g])
      );
      assign BLANK_INTERVAL[g] = bif[g].blank;
    end
  endgenerate

  // fault latches
  logic conv_on_q, conv_on_d;
  logic sd_latch_q, sd_latch_d;
  logic motor_off_q, motor_off_d;
  logic pulse_req_q, pulse_req_d;
  logic prot_default;
  logic hard_fault;

  assign prot_default = (EXTENDED_PROTECTION_CONFIG == 8'h00);
  assign hard_fault = (|cocp) || (|covp) || tsd;

  always_comb begin
    conv_on_d = conv_on_q;
    sd_latch_d = sd_latch_q;
    motor_off_d = motor_off_q;
    pulse_req_d = 1'b0;
    if (vrise) begin
      conv_on_d = 1'b1;
    end else if (!vfall) begin
      conv_on_d = 1'b0;
    end
    if (hard_fault && (prot_default || conv_on_q)) begin
      sd_latch_d = 1'b1;
    end
    if (vlow || sleep_rise) begin
      motor_off_d = 1'b0;
    end
    // a new overcurrent wins over a same-cycle clear
    if (mocp && !motor_off_q) begin
      motor_off_d = 1'b1;
      pulse_req_d = prot_default;
    end else if (mocp) begin
      motor_off_d = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      chop_q <= 3'h0;
      osc_prev_q <= 1'b0;
      sleep_prev_q <= 1'b0;
      conv_on_q <= 1'b0;
      sd_latch_q <= 1'b0;
      motor_off_q <= 1'b0;
      pulse_req_q <= 1'b0;
    end else if (hold_rst) begin
      chop_q <= 3'h0;
      osc_prev_q <= 1'b0;
      sleep_prev_q <= 1'b0;
      conv_on_q <= 1'b0;
      sd_latch_q <= 1'b0;
      motor_off_q <= 1'b0;
      pulse_req_q <= 1'b0;
    end else begin
      chop_q <= chop_d;
      osc_prev_q <= osc;
      sleep_prev_q <= sleep_n;
      conv_on_q <= conv_on_d;
      sd_latch_q <= sd_latch_d;
      motor_off_q <= motor_off_d;
      pulse_req_q <= pulse_req_d;
    end
  end

  // reset output sequencer: each phase spans the full 40 ms figure
  typedef enum logic [1:0] {RS_LOW, RS_HIGH, RS_PULSE} rst_state_e;
  rst_state_e rs_q, rs_d;
  logic [31:0] rcnt_q, rcnt_d;
  logic want_low;
  logic pulse_pend_q, pulse_pend_d;
  assign want_low = sd_latch_q || !conv_on_q || hold_rst;

  always_comb begin
    rs_d = rs_q;
    rcnt_d = rcnt_q;
    pulse_pend_d = pulse_pend_q || pulse_req_q;
    if (hold_rst) begin
      // external reset overrides a running phase and restarts the low phase
      rs_d = RS_LOW;
      rcnt_d = RESET_PHASE_CYCLES - 1;
      pulse_pend_d = 1'b0;
    end else if (rs_q == RS_LOW && want_low) begin
      // low phase is counted from the moment the cause goes away
      rcnt_d = RESET_PHASE_CYCLES - 1;
    end else if (rcnt_q != 32'h0) begin
      rcnt_d = rcnt_q - 32'h1;
    end else begin
      unique case (rs_q)
        RS_LOW: begin
          if (!want_low) begin
            rs_d = RS_HIGH;
            rcnt_d = RESET_PHASE_CYCLES - 1;
          end
        end
        RS_HIGH: begin
          if (want_low) begin
            rs_d = RS_LOW;
            rcnt_d = RESET_PHASE_CYCLES - 1;
          end else if (pulse_pend_q) begin
            rs_d = RS_PULSE;
            pulse_pend_d = 1'b0;
            rcnt_d = RESET_PHASE_CYCLES - 1;
          end
        end
        RS_PULSE: begin
          rs_d = want_low ? RS_LOW : RS_HIGH;
          rcnt_d = RESET_PHASE_CYCLES - 1;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rs_q <= RS_LOW;
      rcnt_q <= 32'h0;
      pulse_pend_q <= 1'b0;
      SYSTEM_RESET_OUT_LOW <= 1'b0;
      CONVERTER_ENABLE <= 1'b0;
      MOTOR_ENABLE <= 1'b0;
    end else begin
      rs_q <= rs_d;
      rcnt_q <= rcnt_d;
      pulse_pend_q <= pulse_pend_d;
      SYSTEM_RESET_OUT_LOW <= (rs_d == RS_HIGH);
      CONVERTER_ENABLE <= conv_on_d && !sd_latch_d && !hold_rst;
      MOTOR_ENABLE <= conv_on_d && !sd_latch_d && !motor_off_d && !hold_rst;
    end
  end
endmodule

// [verification/sup_props.sv]
// Purpose: port-level checks of the fault and blanking supervisor
// Assumes: one clock, async active-low reset
// Notes: async inputs need about five cycles to reach the enables
module sup_props
  import fault_blank_pkg::*;
#(parameter int unsigned RESET_PHASE_CYCLES = 20) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [7:0] SETUP_BITS,
  input wire logic [3:0] BRIDGE_PHASE,
  input wire logic EXT_RESET_IN,
  input wire logic SUPPLY_RISE_THRESHOLD,
  input wire logic SUPPLY_FALL_THRESHOLD,
  input wire logic [2:0] CONV_OVERCURRENT,
  input wire logic MOTOR_OVERCURRENT,
  input wire logic THERMAL_SHUTDOWN,
  input wire logic [3:0] BLANK_INTERVAL,
  input wire logic CONVERTER_ENABLE,
  input wire logic MOTOR_ENABLE,
  input wire logic SYSTEM_RESET_OUT_LOW
);
  int unsigned low_q;
  int unsigned low_d;
  always_comb low_d = SYSTEM_RESET_OUT_LOW ? 32'h0 : low_q + 32'h1;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) low_q <= 32'h0;
    else low_q <= low_d;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_conv_fault; (|CONV_OVERCURRENT && !EXT_RESET_IN) [*7]; endsequence
  sequence s_heat; (THERMAL_SHUTDOWN && !EXT_RESET_IN) [*7]; endsequence
  AST_RESET_OUTS: assert property ($rose(RST_N) |-> !CONVERTER_ENABLE && !MOTOR_ENABLE && !SYSTEM_RESET_OUT_LOW)
    else $error("outputs not clear after reset");
  AST_EXT_STOP: assert property (EXT_RESET_IN [*6] |-> !CONVERTER_ENABLE && !MOTOR_ENABLE)
    else $error("external reset did not stop outputs");
  AST_CONV_FAULT: assert property (s_conv_fault |-> !CONVERTER_ENABLE && !MOTOR_ENABLE && !SYSTEM_RESET_OUT_LOW)
    else $error("converter fault did not shut down");
  AST_HEAT: assert property (s_heat |-> !CONVERTER_ENABLE && !MOTOR_ENABLE && !SYSTEM_RESET_OUT_LOW)
    else $error("thermal fault did not shut down");
  AST_MOTOR_OFF: assert property ((MOTOR_OVERCURRENT && !EXT_RESET_IN) [*6] |-> !MOTOR_ENABLE)
    else $error("motor overcurrent left bridges on");
  AST_LOW_PHASE: assert property ($rose(SYSTEM_RESET_OUT_LOW) |-> low_q >= RESET_PHASE_CYCLES - 1)
    else $error("reset output low phase too short");
  AST_CONV_RISE: assert property ($rose(CONVERTER_ENABLE) |-> $past(SUPPLY_RISE_THRESHOLD, 3))
    else $error("converters on without rising threshold");
  AST_CONV_FALL: assert property ((!SUPPLY_FALL_THRESHOLD) [*7] |-> !CONVERTER_ENABLE)
    else $error("converters on below falling threshold");
  AST_BLANK_A: assert property ($changed(BRIDGE_PHASE[0]) && SETUP_BITS[4:3] == BLANK_SEL_SHORT |=> BLANK_INTERVAL[0])
    else $error("no blanking after phase reversal");
endmodule
bind motor_fault_blanking_supervisor sup_props #(.RESET_PHASE_CYCLES(RESET_PHASE_CYCLES)) sup_props_i (
  .REF_CLK, .RST_N, .SETUP_BITS, .BRIDGE_PHASE, .EXT_RESET_IN, .SUPPLY_RISE_THRESHOLD, .SUPPLY_FALL_THRESHOLD,
  .CONV_OVERCURRENT, .MOTOR_OVERCURRENT, .THERMAL_SHUTDOWN, .BLANK_INTERVAL, .CONVERTER_ENABLE, .MOTOR_ENABLE,
  .SYSTEM_RESET_OUT_LOW);

// [verification/host_model.sv]
// Purpose: host that toggles the sleep request on demand
// Assumes: wake_req is a short pulse from the bench
// Notes: sleep request stays high outside a toggle
module host_model (
  input wire logic clk,
  input wire logic wake_req,
  output logic sleep_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial sleep_n = 1'b1;
  always @(posedge wake_req) begin
    sleep_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1 sleep_n <= 1'b1;
  end
endmodule

// [verification/testbench.sv]
// Purpose: self-checking bench for the fault and blanking supervisor
// Assumes: motor oscillator tick every four clocks
// Notes: reset phase shortened to 20 cycles
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int P = 20;
  logic clk = 0, rst_n = 0, osc = 0, ext = 0, rise = 0, fall = 0, low45 = 0, mot_oc = 0, heat = 0, wake = 0;
  logic [7:0] setup = 8'h00;
  logic [3:0] phase = 4'h0;
  logic [2:0] c_oc = 3'h0, c_ov = 3'h0;
  logic [3:0] blank;
  logic conv_en, mot_en, rst_out_n, sleep_n;
  int n_fail = 0, n_tests = 0;
  always #5 clk = ~clk;
  always #20 osc = ~osc;
  motor_fault_blanking_supervisor #(.RESET_PHASE_CYCLES(P)) motor_fault_blanking_supervisor_i (
    .REF_CLK(clk), .RST_N(rst_n), .MOTOR_OSC_CLOCK(osc), .SETUP_BITS(setup),
    .EXTENDED_PROTECTION_CONFIG(8'h00),
    .BRIDGE_PHASE(phase), .LOW_POWER_REQUEST_IN(sleep_n), .EXT_RESET_IN(ext), .SUPPLY_RISE_THRESHOLD(rise),
    .SUPPLY_FALL_THRESHOLD(fall), .SUPPLY_BELOW_4V5(low45), .CONV_OVERCURRENT(c_oc), .CONV_OVERVOLTAGE(c_ov),
    .MOTOR_OVERCURRENT(mot_oc), .THERMAL_SHUTDOWN(heat), .BLANK_INTERVAL(blank), .CONVERTER_ENABLE(conv_en),
    .MOTOR_ENABLE(mot_en), .SYSTEM_RESET_OUT_LOW(rst_out_n));
  host_model host_model_i (.clk(clk), .wake_req(wake), .sleep_n(sleep_n));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // index 4 waits on the reset output, others on a bridge blank
  task automatic till(input int b, input logic v, output int k);
    k = 0;
    while (((b == 4) ? rst_out_n : blank[b]) !== v && k < 400) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic power_up;
    int k;
    rst_n = 0;
    cyc(8);
    check("outputs in reset", {conv_en, mot_en, rst_out_n}, 3'h0);
    rst_n = 1;
    rise = 1;
    fall = 1;
    till(4, 1, k);
    check("reset low span", k >= P, 1);
    check("conv on", {conv_en, mot_en}, 2'h3);
  endtask
  task automatic blank_run(input int b, input logic [7:0] s, input int n);
    int k, j;
    setup = s;
    till(b, 1, k);
    till(b, 0, k);
    till(b, 1, k);
    till(b, 0, k);
    check("blank span", k >= 4 * n - 4 && k <= 4 * n + 4, 1);
    till(b, 1, j);
    check("chop period", k + j >= 31 && k + j <= 33, 1);
    if (n == 3) begin
      till(b, 0, k);
      cyc(2);
      phase[b] = ~phase[b];
      cyc(2);
      check("reversal blank", blank[b], 1);
    end
  endtask
  task automatic motor_trip(input int m);
    int k;
    mot_oc = 1;
    cyc(8);
    check("motor off conv kept", {mot_en, conv_en}, 2'h1);
    mot_oc = 0;
    till(4, 0, k);
    till(4, 1, k);
    check("pulse low span", k >= P - 1 && k <= P + 1, 1);
    check("motor stays off", mot_en, 0);
    if (m == 0) wake = 1;
    else low45 = 1;
    cyc(8);
    wake = 0;
    low45 = 0;
    cyc(12);
    check("motor back", mot_en, 1);
  endtask
  task automatic conv_trip(input int f);
    // a running high phase of the reset output must finish first
    cyc(P);
    {heat, c_ov, c_oc} = 7'h01 << f;
    cyc(8);
    check("shut down", {conv_en, mot_en, rst_out_n}, 3'h0);
    {heat, c_ov, c_oc} = 7'h00;
    cyc(10);
    check("shut latched", {conv_en, mot_en, rst_out_n}, 3'h0);
    power_up;
  endtask
  task automatic ext_and_supply;
    int k;
    ext = 1;
    cyc(8);
    check("ext stop", {conv_en, mot_en}, 2'h0);
    ext = 0;
    till(4, 1, k);
    check("restart span", k >= P && conv_en === 1'b1, 1);
    rise = 0;
    cyc(10);
    check("hysteresis hold", conv_en, 1);
    fall = 0;
    cyc(10);
    check("fall stop", conv_en, 0);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    power_up;
    blank_run(0, 8'h10, 3);
    blank_run(0, 8'h08, 6);
    blank_run(2, 8'h20, 3);
    blank_run(2, 8'h40, 6);
    motor_trip(0);
    motor_trip(1);
    for (int f = 0; f < 7; f++) conv_trip(f);
    ext_and_supply;
    tally_and_finish;
  end
endmodule
